/* File: hdl/htc_config.v */
// Purpose: hybrid eighth tap and on-hook release configuration registers
// Assumes: one 100 MHz clock, synchronous active high reset
// Notes: release times are parameters so a simulation can shorten them
`timescale 1ns/1ns
`include "htc_defs.vh"

module htc_config #(
  parameter [`HTC_CNT_W-1:0] FAST_CYC = `HTC_T_FAST_US * `HTC_CLK_MHZ,
  parameter [`HTC_CNT_W-1:0] ETSI_CYC = `HTC_T_ETSI_US * `HTC_CLK_MHZ,
  parameter [`HTC_CNT_W-1:0] AUS_CYC = `HTC_T_AUS_US * `HTC_CLK_MHZ
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // serial control port
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  output wire sdo,
  output wire sdo_oe,
  // companion bits held elsewhere
  input wire off_hook_control_bit,
  input wire hook_speed_first_bit,
  input wire hook_speed_second_bit,
  input wire companion_guard_bit,
  input wire line_rev_e_or_later,
  // hybrid filter side
  output reg [7:0] tap_eight_coeff,
  output reg tap_eight_active,
  output reg rx_hybrid_gain_1db,
  // line side
  output reg loop_current_enable,
  output reg release_busy,
  output reg guard_current_enable
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RELEASE = 1'b1;

  reg [7:0] hybrid_tap_eight_coeff;
  reg quench_time_high_bit;
  reg quench_time_low_bit;
  reg receive_gain_bit;
  reg guarded_clear_enable;
  reg state;
  reg off_hook_q;
  reg [`HTC_CNT_W-1:0] rel_cnt;
  reg [`HTC_CNT_W-1:0] rel_len;
  reg [7:0] rd_data;
  reg next_state;
  wire [`HTC_ADDR_W-1:0] addr;
  wire [7:0] wr_data;
  wire wr_stb;
  wire hook_released;

  htc_serial_port u_port (
    .core_clk(core_clk),
    .rst(rst),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .rd_data(rd_data),
    .addr(addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb)
  );

  // read mux, reserved and unmapped addresses read zero
  always @* begin
    case (addr)
      `HTC_ADDR_TAP8: rd_data = hybrid_tap_eight_coeff;
      `HTC_ADDR_RELCTL: rd_data = {1'b0, quench_time_high_bit, 1'b0, quench_time_low_bit,
                                   1'b0, receive_gain_bit, guarded_clear_enable, 1'b0};
      default: rd_data = 8'h00;
    endcase
  end

  // register writes; reserved addresses and bits are dropped
  always @(posedge core_clk) begin
    if (rst) begin
      hybrid_tap_eight_coeff <= `HTC_RST_TAP8;
      quench_time_high_bit <= `HTC_RST_BIT;
      quench_time_low_bit <= `HTC_RST_BIT;
      receive_gain_bit <= `HTC_RST_BIT;
      guarded_clear_enable <= `HTC_RST_BIT;
    end else if (wr_stb) begin
      if (addr == `HTC_ADDR_TAP8) begin
        hybrid_tap_eight_coeff <= wr_data;
      end
      if (addr == `HTC_ADDR_RELCTL) begin
        quench_time_high_bit <= wr_data[`HTC_BIT_QUENCH_HI];
        quench_time_low_bit <= wr_data[`HTC_BIT_QUENCH_LO];
        receive_gain_bit <= wr_data[`HTC_BIT_RX_GAIN];
        guarded_clear_enable <= wr_data[`HTC_BIT_GUARD_EN];
      end
    end
  end

  // release length from hook speed and quench selection
  always @* begin
    case ({hook_speed_first_bit, hook_speed_second_bit, quench_time_high_bit, quench_time_low_bit})
      4'b0100: rel_len = ETSI_CYC;
      4'b1011: rel_len = AUS_CYC;
      4'b1111: rel_len = AUS_CYC;
      default: rel_len = FAST_CYC;
    endcase
  end

  assign hook_released = off_hook_q & ~off_hook_control_bit;

  always @* begin
    case (state)
      ST_IDLE: next_state = hook_released ? ST_RELEASE : ST_IDLE;
      ST_RELEASE: begin
        if (off_hook_control_bit) begin
          next_state = ST_IDLE;
        end else begin
          next_state = (rel_cnt <= 22'h00_0001) ? ST_IDLE : ST_RELEASE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // release timer: loop current is held until the count runs out
  always @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      off_hook_q <= 1'b0;
      rel_cnt <= 22'h00_0000;
      loop_current_enable <= 1'b0;
      release_busy <= 1'b0;
    end else begin
      state <= next_state;
      off_hook_q <= off_hook_control_bit;
      if (state == ST_IDLE && hook_released) begin
        rel_cnt <= rel_len;
      end else if (state == ST_RELEASE && rel_cnt != 22'h00_0000) begin
        rel_cnt <= rel_cnt - 22'h00_0001;
      end
      release_busy <= (next_state == ST_RELEASE);
      loop_current_enable <= off_hook_control_bit | (next_state == ST_RELEASE);
    end
  end

  // hybrid and line-side controls
  always @(posedge core_clk) begin
    if (rst) begin
      tap_eight_coeff <= `HTC_RST_TAP8;
      tap_eight_active <= 1'b0;
      rx_hybrid_gain_1db <= 1'b0;
      guard_current_enable <= 1'b0;
    end else begin
      tap_eight_coeff <= hybrid_tap_eight_coeff;
      tap_eight_active <= |hybrid_tap_eight_coeff;
      rx_hybrid_gain_1db <= receive_gain_bit & line_rev_e_or_later;
      // off whenever loop current will flow, first release cycle included
      guard_current_enable <= guarded_clear_enable & companion_guard_bit & line_rev_e_or_later &
                              ~off_hook_control_bit & (next_state != ST_RELEASE);
    end
  end
endmodule // htc_config

/* File: hdl/htc_defs.vh */
// Purpose: constants for the hybrid tap and hook configuration block
// Assumes: core clock of 100 MHz
// Notes: times are in microseconds, counts derived in the top module
`ifndef HTC_DEFS_VH
`define HTC_DEFS_VH

// register addresses
`define HTC_ADDR_W 6
`define HTC_ADDR_TAP8 6'h34
`define HTC_ADDR_RSVD_LO 6'h35
`define HTC_ADDR_RSVD_HI 6'h3a
`define HTC_ADDR_RELCTL 6'h3b

// release control field positions
`define HTC_BIT_QUENCH_HI 6
`define HTC_BIT_QUENCH_LO 4
`define HTC_BIT_RX_GAIN 2
`define HTC_BIT_GUARD_EN 1

// reset values
`define HTC_RST_TAP8 8'h00
`define HTC_RST_BIT 1'b0

// serial frame
`define HTC_CMD_READ_BIT 7
`define HTC_FRAME_BITS 5'h10
`define HTC_CMD_LAST 4'h7
`define HTC_DATA_FIRST 4'h8
`define HTC_FRAME_LAST 4'hf

// release timing
`define HTC_CLK_MHZ 100
`define HTC_T_FAST_US 500
`define HTC_T_ETSI_US 3000
`define HTC_T_AUS_US 26000
`define HTC_CNT_W 22

`endif

/* File: hdl/htc_serial_port.v */
// Purpose: serial control port slave, 8-bit command then 8-bit data
// Assumes: port pins synchronous to core_clk, sclk idles low
// Notes: command bit 7 selects read, bits 5:0 the address
`timescale 1ns/1ns
`include "htc_defs.vh"

module htc_serial_port (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // port pins
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,
  // register side
  input wire [7:0] rd_data,
  output reg [`HTC_ADDR_W-1:0] addr,
  output reg [7:0] wr_data,
  output reg wr_stb
);
  reg sclk_q;
  reg [3:0] bit_cnt;
  reg [6:0] shift_in;
  reg [6:0] shift_out;
  reg is_read;
  wire sclk_rise;
  wire sclk_fall;

  // edges only count while selected
  assign sclk_rise = ~cs_n & sclk & ~sclk_q;
  assign sclk_fall = ~cs_n & ~sclk & sclk_q;

  always @(posedge core_clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      bit_cnt <= 4'h0;
      shift_in <= 7'h00;
      shift_out <= 7'h00;
      is_read <= 1'b0;
      addr <= {`HTC_ADDR_W{1'b0}};
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sclk_q <= sclk;
      wr_stb <= 1'b0;
      if (cs_n) begin
        bit_cnt <= 4'h0;
        sdo_oe <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_in <= {shift_in[5:0], sdi};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `HTC_CMD_LAST) begin
            is_read <= shift_in[`HTC_CMD_READ_BIT-1];
            addr <= {shift_in[`HTC_ADDR_W-2:0], sdi};
          end
          if (bit_cnt == `HTC_FRAME_LAST && !is_read) begin
            wr_data <= {shift_in, sdi};
            wr_stb <= 1'b1;
          end
        end
        if (sclk_fall && is_read && bit_cnt >= `HTC_DATA_FIRST) begin
          if (bit_cnt == `HTC_DATA_FIRST) begin
            sdo <= rd_data[7];
            shift_out <= rd_data[6:0];
            sdo_oe <= 1'b1;
          end else begin
            sdo <= shift_out[6];
            shift_out <= {shift_out[5:0], 1'b0};
          end
        end
      end
    end
  end
endmodule // htc_serial_port

/* File: testbench/htc_config_chk.sv */
// Purpose: port checks for htc_config
// Assumes: one clock, synchronous reset
// Notes: bound to every htc_config instance
`timescale 1ns/1ns
module htc_config_chk (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // serial port
  input logic cs_n,
  input logic sclk,
  input logic sdi,
  input logic sdo,
  input logic sdo_oe,
  // companion inputs
  input logic off_hook_control_bit,
  input logic hook_speed_first_bit,
  input logic hook_speed_second_bit,
  input logic companion_guard_bit,
  input logic line_rev_e_or_later,
  // outputs
  input logic [7:0] tap_eight_coeff,
  input logic tap_eight_active,
  input logic rx_hybrid_gain_1db,
  input logic loop_current_enable,
  input logic release_busy,
  input logic guard_current_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_hang_up;
    $fell(off_hook_control_bit);
  endsequence
  sequence s_release_run;
    ##2 release_busy && loop_current_enable;
  endsequence
  a_tap_active_nz: assert property (tap_eight_active == (tap_eight_coeff != 8'h00))
    else $error("tap activity wrong");
  a_gain_rev_gate: assert property (!line_rev_e_or_later |=> !rx_hybrid_gain_1db)
    else $error("gain without revision");
  a_guard_rev_gate: assert property (!(companion_guard_bit && line_rev_e_or_later) |=> !guard_current_enable)
    else $error("guard current ungated");
  a_guard_on_hook: assert property (!(guard_current_enable && loop_current_enable))
    else $error("guard current off-hook");
  a_busy_loop: assert property (release_busy |-> loop_current_enable)
    else $error("loop dropped in release");
  a_release_start: assert property (s_hang_up |-> s_release_run)
    else $error("release did not start");
  a_off_hook_loop: assert property (off_hook_control_bit |=> loop_current_enable)
    else $error("no loop current off-hook");
  a_oe_idle: assert property (cs_n ##1 cs_n |-> !sdo_oe)
    else $error("sdo driven while deselected");
endmodule // htc_config_chk
bind htc_config htc_config_chk htc_config_chk_i (.*);

/* File: testbench/htc_host.sv */
// Purpose: host controller model on the serial port
// Assumes: 16-bit frames, command byte first
// Notes: sclk idles low, sdi inverted after each frame
`timescale 1ns/1ns
module htc_host (
  // clock
  input wire core_clk,
  // serial port
  output reg cs_n,
  output reg sclk,
  output reg sdi,
  input wire sdo,
  input wire sdo_oe
);
  reg [15:0] sh;
  integer k;
  initial begin
    cs_n = 1;
    sclk = 0;
    sdi = 0;
  end
  task xfer(input sel, input [7:0] cmd, input [7:0] wd, output [7:0] rd);
    begin
      sh = {cmd, cmd[7] ? 8'h00 : (cmd[5:0] == 6'h3b ? wd & 8'h56 : wd)};
      @(posedge core_clk);
      cs_n <= ~sel;
      repeat (2) @(posedge core_clk);
      for (k = 15; k >= 0; k--) begin
        sdi <= sh[k];
        sclk <= 0;
        repeat (4) @(posedge core_clk);
        if (k < 8) rd[k] = sdo_oe ? sdo : 1'bx;
        sclk <= 1;
        repeat (3) @(posedge core_clk);
      end
      sclk <= 0;
      repeat (2) @(posedge core_clk);
      cs_n <= 1;
      sdi <= ~sdi;
      repeat (3) @(posedge core_clk);
    end
  endtask
endmodule // htc_host

/* File: testbench/tb.sv */
// Purpose: self-checking bench for htc_config
// Assumes: shortened release counts 5, 30, 260
// Notes: registers reached through the host model
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
  reg core_clk = 0, rst = 1, ohk = 0, hs1 = 0, hs2 = 0, grd = 0, rev = 1;
  wire cs_n, sclk, sdi, sdo, sdo_oe, act, gain, loop, busy, guard;
  wire [7:0] coeff;
  reg [7:0] rd;
  integer fail_count = 0, compares = 0, i, n;
  always #5 core_clk = ~core_clk;
  htc_host htc_host_i (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  htc_config #(.FAST_CYC(5), .ETSI_CYC(30), .AUS_CYC(260)) htc_config_i (.core_clk(core_clk), .rst(rst),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .off_hook_control_bit(ohk),
    .hook_speed_first_bit(hs1), .hook_speed_second_bit(hs2), .companion_guard_bit(grd),
    .line_rev_e_or_later(rev), .tap_eight_coeff(coeff), .tap_eight_active(act), .rx_hybrid_gain_1db(gain),
    .loop_current_enable(loop), .release_busy(busy), .guard_current_enable(guard));
  task finish_test;
    begin
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    htc_host_i.xfer(1'b1, a, d, rd);
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      htc_host_i.xfer(1'b1, 8'h80 | a, 8'h00, rd);
      `CHK("reg", e, rd)
    end
  endtask
  task rel(input h1, input h2, input [7:0] q, input integer c);
    begin
      hs1 <= h1;
      hs2 <= h2;
      wr(8'h3b, q);
      ohk <= 1;
      repeat (4) @(posedge core_clk);
      ohk <= 0;
      n = 0;
      for (i = 0; i < 400 && !(n > 0 && !busy); i++) begin
        @(posedge core_clk);
        if (busy) n++;
      end
      `CHK("release", 1'b1, n >= c && n <= c + 4)
      `CHK("loop", 1'b0, loop)
      `CHK("guard", q[1], guard)
      if (i >= 400) begin
        fail_count++;
        finish_test;
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rdc(8'h34, 8'h00);
    rdc(8'h3b, 8'h00);
    `CHK("active", 1'b0, act)
    wr(8'h34, 8'ha5);
    rdc(8'h34, 8'ha5);
    `CHK("coeff", 8'ha5, coeff)
    `CHK("active", 1'b1, act)
    htc_host_i.xfer(1'b0, 8'h34, 8'h00, rd);
    rdc(8'h34, 8'ha5);
    rdc(8'h35, 8'h00);
    wr(8'h3b, 8'h56);
    grd <= 1;
    rdc(8'h3b, 8'h56);
    `CHK("gain", 1'b1, gain)
    `CHK("guard", 1'b1, guard)
    rev <= 0;
    repeat (2) @(posedge core_clk);
    `CHK("gated", 2'b00, {gain, guard})
    rev <= 1;
    rel(1'b0, 1'b0, 8'h00, 5);
    rel(1'b0, 1'b1, 8'h00, 30);
    rel(1'b1, 1'b0, 8'h50, 260);
    rel(1'b1, 1'b1, 8'h52, 260);
    rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    `CHK("coeff", 8'h00, coeff)
    `CHK("guard", 1'b0, guard)
    rdc(8'h34, 8'h00);
    rdc(8'h3b, 8'h00);
    finish_test;
  end
endmodule // tb
